/* File: src/osh_map.svh */
`ifndef OSH_MAP_SVH
`define OSH_MAP_SVH

`define OSH_REG_COUNT      5
`define OSH_SEL_SUMMARY    3'h0
`define OSH_SEL_CALIB      3'h1
`define OSH_SEL_MEAS       3'h2
`define OSH_SEL_TRIG       3'h3
`define OSH_SEL_INIT       3'h4

`define OSH_BIT_CALIB      0
`define OSH_BIT_MEAS       4
`define OSH_BIT_TRIG       5
`define OSH_BIT_INIT       10
`define OSH_BIT_LLIM       11
`define OSH_BIT_ULIM       12
`define OSH_SENSOR_LSB     1

`define OSH_USED_SUMMARY   16'h1c31
`define OSH_USED_SENSOR    16'h001e

`define OSH_RST_WORD       16'h0000
`define OSH_RST_INIT       4'hf
`define OSH_RST_CONN       4'h0

`endif

/* File: src/osh_pkg.sv */
package osh_pkg;
	typedef logic [15:0] osh_word_t;
	typedef logic [3:0]  osh_sensor_t;
	typedef logic [2:0]  osh_sel_t;
	typedef enum logic { OSH_VIEW_COND, OSH_VIEW_EVENT } osh_view_t;
endpackage

/* File: src/osh_status_unit.sv */
`timescale 1ns/1ps
`include "osh_map.svh"
module osh_status_unit #(
	parameter logic [15:0] USED_MASK = `OSH_USED_SENSOR
) (
	input  wire logic  clk_in,
	input  wire logic  resetn_in,
	osh_unit_if.unit   bus
);
	osh_pkg::osh_word_t cond_reg;
	osh_pkg::osh_word_t cond_next;
	osh_pkg::osh_word_t event_reg;
	osh_pkg::osh_word_t event_next;
	osh_pkg::osh_word_t rise;
	osh_pkg::osh_word_t fall;

	assign cond_next  = bus.cond & USED_MASK;
	assign rise       = cond_next & ~cond_reg;
	assign fall       = ~cond_next & cond_reg;
	// New edges win over a readout clear in the same cycle
	assign event_next = ((bus.rd_clr ? `OSH_RST_WORD : event_reg)
		| (rise & bus.ptr) | (fall & bus.ntr)) & USED_MASK;

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			cond_reg  <= `OSH_RST_WORD;
			event_reg <= `OSH_RST_WORD;
		end
		else
		begin
			cond_reg  <= cond_next;
			event_reg <= event_next;
		end
	end

	assign bus.cond_view  = cond_reg;
	assign bus.event_view = event_reg;
endmodule

/* File: src/osh_top.sv */
`timescale 1ns/1ps
`include "osh_map.svh"
module osh_top (
	input  wire logic                                clk_in,
	input  wire logic                                resetn_in,
	input  wire osh_pkg::osh_sensor_t                calib_active_in,
	input  wire osh_pkg::osh_sensor_t                meas_active_in,
	input  wire osh_pkg::osh_sensor_t                trigger_wait_state_in,
	input  wire osh_pkg::osh_sensor_t                sensor_connected_in,
	input  wire osh_pkg::osh_sensor_t                init_done_in,
	input  wire logic                                preset_cmd_in,
	input  wire logic                                lower_limit_fail_in,
	input  wire logic                                upper_limit_fail_in,
	input  wire logic [`OSH_REG_COUNT-1:0][15:0]     ptr_cfg_in,
	input  wire logic [`OSH_REG_COUNT-1:0][15:0]     ntr_cfg_in,
	input  wire logic [`OSH_REG_COUNT-1:0][15:0]     enable_cfg_in,
	input  wire logic                                query_valid_in,
	input  wire osh_pkg::osh_sel_t                   query_sel_in,
	input  wire osh_pkg::osh_view_t                  query_view_in,
	output logic                                     answer_valid_out,
	output osh_pkg::osh_word_t                       answer_out,
	output osh_pkg::osh_word_t                       summary_cond_out
);
	localparam logic [`OSH_REG_COUNT-1:0][15:0] USED_MASKS = {
		`OSH_USED_SENSOR, `OSH_USED_SENSOR, `OSH_USED_SENSOR,
		`OSH_USED_SENSOR, `OSH_USED_SUMMARY};

	////////////////////////////////////////////////////////////////////////////////
	// Sensor initialization tracking
	osh_pkg::osh_sensor_t init_reg;
	osh_pkg::osh_sensor_t init_next;
	osh_pkg::osh_sensor_t conn_prev_reg;
	osh_pkg::osh_sensor_t conn_rise;

	assign conn_rise = sensor_connected_in & ~conn_prev_reg;
	// Start wins over completion reported in the same cycle
	assign init_next = (init_reg & ~init_done_in) | conn_rise
		| {4{preset_cmd_in}};

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			init_reg      <= `OSH_RST_INIT;
			conn_prev_reg <= `OSH_RST_CONN;
		end
		else
		begin
			init_reg      <= init_next;
			conn_prev_reg <= sensor_connected_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Condition sources
	osh_pkg::osh_word_t   cond_src [`OSH_REG_COUNT];
	osh_pkg::osh_word_t   cond_view [`OSH_REG_COUNT];
	osh_pkg::osh_word_t   event_view [`OSH_REG_COUNT];
	osh_pkg::osh_sensor_t trig_wait;
	logic                 sum_calib;
	logic                 sum_meas;
	logic                 sum_trig;
	logic                 sum_init;
	osh_pkg::osh_word_t   summary_src;

	// A triggered sensor has moved to measuring and no longer waits
	assign trig_wait = trigger_wait_state_in & ~meas_active_in;

	assign cond_src[`OSH_SEL_CALIB] = {11'h000, calib_active_in, 1'b0};
	assign cond_src[`OSH_SEL_MEAS]  = {11'h000, meas_active_in, 1'b0};
	assign cond_src[`OSH_SEL_TRIG]  = {11'h000, trig_wait, 1'b0};
	assign cond_src[`OSH_SEL_INIT]  = {11'h000, init_reg, 1'b0};

	assign sum_calib = |(event_view[`OSH_SEL_CALIB] & enable_cfg_in[`OSH_SEL_CALIB]);
	assign sum_meas  = |(event_view[`OSH_SEL_MEAS] & enable_cfg_in[`OSH_SEL_MEAS]);
	assign sum_trig  = |(event_view[`OSH_SEL_TRIG] & enable_cfg_in[`OSH_SEL_TRIG]);
	assign sum_init  = |(event_view[`OSH_SEL_INIT] & enable_cfg_in[`OSH_SEL_INIT]);

	// Summary word built in its own variable so the array has one kind of driver
	assign cond_src[`OSH_SEL_SUMMARY] = summary_src;

	always_comb
	begin
		summary_src                 = `OSH_RST_WORD;
		summary_src[`OSH_BIT_CALIB] = sum_calib;
		summary_src[`OSH_BIT_MEAS]  = sum_meas;
		summary_src[`OSH_BIT_TRIG]  = sum_trig;
		summary_src[`OSH_BIT_INIT]  = sum_init;
		summary_src[`OSH_BIT_LLIM]  = lower_limit_fail_in;
		summary_src[`OSH_BIT_ULIM]  = upper_limit_fail_in;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status registers
	logic query_event;
	logic sel_ok;

	assign query_event = query_valid_in && (query_view_in == osh_pkg::OSH_VIEW_EVENT);
	assign sel_ok      = (query_sel_in <= `OSH_SEL_INIT);

	osh_unit_if u_if [`OSH_REG_COUNT] ();

	genvar i;
	generate
		for (i = 0; i < `OSH_REG_COUNT; i++)
		begin : g_unit
			assign u_if[i].cond   = cond_src[i];
			assign u_if[i].ptr    = ptr_cfg_in[i];
			assign u_if[i].ntr    = ntr_cfg_in[i];
			// Event readout and preset both clear the event view
			assign u_if[i].rd_clr = preset_cmd_in
				|| (query_event && (query_sel_in == 3'(i)));
			assign cond_view[i]   = u_if[i].cond_view;
			assign event_view[i]  = u_if[i].event_view;
			osh_status_unit #(
				.USED_MASK (USED_MASKS[i])
			) u_unit (
				.clk_in    (clk_in),
				.resetn_in (resetn_in),
				.bus       (u_if[i].unit)
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Query answer
	osh_pkg::osh_word_t answer_next;

	assign answer_next = !sel_ok ? `OSH_RST_WORD :
		(query_view_in == osh_pkg::OSH_VIEW_EVENT) ? event_view[query_sel_in]
		: cond_view[query_sel_in];

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			answer_valid_out <= 1'b0;
			answer_out       <= `OSH_RST_WORD;
			summary_cond_out <= `OSH_RST_WORD;
		end
		else
		begin
			answer_valid_out <= query_valid_in;
			if (query_valid_in)
			begin
				answer_out <= answer_next;
			end
			summary_cond_out <= cond_view[`OSH_SEL_SUMMARY];
		end
	end
endmodule

/* File: src/osh_unit_if.sv */
`timescale 1ns/1ps
interface osh_unit_if;
	osh_pkg::osh_word_t cond;
	osh_pkg::osh_word_t ptr;
	osh_pkg::osh_word_t ntr;
	logic               rd_clr;
	osh_pkg::osh_word_t cond_view;
	osh_pkg::osh_word_t event_view;
	modport unit (input cond, input ptr, input ntr, input rd_clr,
		output cond_view, output event_view);
	modport ctrl (output cond, output ptr, output ntr, output rd_clr,
		input cond_view, input event_view);
endinterface

/* File: testbench/osh_top_monitor.sv */
`timescale 1ns/1ps
module osh_top_monitor (
	input wire logic               clk_in,
	input wire logic               resetn_in,
	input wire logic               query_valid_in,
	input wire osh_pkg::osh_sel_t  query_sel_in,
	input wire logic               lower_limit_fail_in,
	input wire logic               upper_limit_fail_in,
	input wire logic               answer_valid_out,
	input wire osh_pkg::osh_word_t answer_out,
	input wire osh_pkg::osh_word_t summary_cond_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	////////////////////////////////////////////////////////////////////////////////
	a_answer_next: assert property (query_valid_in |=> answer_valid_out)
		else $error("answer missing");
	a_answer_lone: assert property (!query_valid_in |=> !answer_valid_out)
		else $error("answer without query");
	a_answer_hold: assert property (!query_valid_in |=> $stable(answer_out))
		else $error("answer changed without query");
	a_sel_zero: assert property (query_valid_in && query_sel_in > 3'h4 |=> !answer_out)
		else $error("bad select answered nonzero");
	a_top_clean: assert property ((summary_cond_out & 16'he3ce) == 16'h0000)
		else $error("unused summary bit set");
	a_sub_clean: assert property (answer_valid_out && $past(query_sel_in) != 3'h0
		|-> (answer_out & 16'hffe1) == 16'h0000) else $error("unused sensor bit set");
	a_top_answer: assert property (answer_valid_out && $past(query_sel_in) == 3'h0
		|-> (answer_out & 16'he3ce) == 16'h0000) else $error("unused top bit set");
	a_low_limit: assert property (lower_limit_fail_in [*4] |-> summary_cond_out[11])
		else $error("lower limit summary missing");
	a_up_limit: assert property (upper_limit_fail_in [*4] |-> summary_cond_out[12])
		else $error("upper limit summary missing");
	c_calib_read: cover property (query_valid_in && query_sel_in == 3'h1);
	c_bad_sel: cover property (query_valid_in && query_sel_in == 3'h7);
	c_limits: cover property (summary_cond_out[11] && summary_cond_out[12]);
endmodule

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	localparam osh_pkg::osh_view_t C = osh_pkg::OSH_VIEW_COND;
	localparam osh_pkg::osh_view_t E = osh_pkg::OSH_VIEW_EVENT;
	logic                 clk_in = 1'b0;
	logic                 resetn_in = 1'b0;
	logic                 pre = 1'b0, ll = 1'b0, ul = 1'b0, qv = 1'b0, av;
	osh_pkg::osh_sensor_t cal = 4'h0, mea = 4'h0, trg = 4'h0, con = 4'h0, dn = 4'h0;
	logic [4:0][15:0]     ptr = {5{16'hffff}}, ntr = '0, en = {5{16'hffff}};
	osh_pkg::osh_sel_t    sel = 3'h0;
	osh_pkg::osh_view_t   vw = C;
	osh_pkg::osh_word_t   ans, sum;
	int                   n_mismatch = 0, checked = 0;
	osh_top dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .calib_active_in(cal),
		.meas_active_in(mea), .trigger_wait_state_in(trg), .sensor_connected_in(con),
		.init_done_in(dn), .preset_cmd_in(pre), .lower_limit_fail_in(ll),
		.upper_limit_fail_in(ul), .ptr_cfg_in(ptr), .ntr_cfg_in(ntr), .enable_cfg_in(en),
		.query_valid_in(qv), .query_sel_in(sel), .query_view_in(vw),
		.answer_valid_out(av), .answer_out(ans), .summary_cond_out(sum));
	initial forever #2.5 clk_in = ~clk_in;
	////////////////////////////////////////////////////////////////////////////////
	task final_report;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input string nm, input osh_pkg::osh_word_t g, input osh_pkg::osh_word_t e);
		checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error %s sel %0d exp %h got %h", nm, sel, e, g);
		end
	endtask
	task w(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// One query; answer must come one edge after it is taken
	task q(input osh_pkg::osh_sel_t s, input osh_pkg::osh_view_t v, input osh_pkg::osh_word_t e);
		@(posedge clk_in);
		qv <= 1'b1;
		sel <= s;
		vw <= v;
		@(posedge clk_in);
		qv <= 1'b0;
		#1;
		chk("answer_valid_out", {15'h0000, av}, 16'h0001);
		chk("answer_out", ans, e);
		@(posedge clk_in);
	endtask
	task src(input int s, input osh_pkg::osh_sensor_t v);
		case (s)
			1: cal <= v;
			2: mea <= v;
			default: trg <= v;
		endcase
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task s_power_up;
		w(4);
		q(3'h0, C, 16'h0400);
		q(3'h4, C, 16'h001e);
		q(3'h4, E, 16'h001e);
		q(3'h4, E, 16'h0000);
	endtask
	task s_sub(input int s);
		osh_pkg::osh_word_t b;
		b = 16'h0001 << (s == 1 ? 0 : s + 2);
		src(s, 4'h9);
		w(4);
		q(s[2:0], C, 16'h0012);
		q(3'h0, C, b);
		q(s[2:0], E, 16'h0012);
		q(s[2:0], E, 16'h0000);
		src(s, 4'h0);
		w(4);
		q(s[2:0], E, 16'h0000);
		ptr[s] <= 16'h0000;
		ntr[s] <= 16'hffff;
		src(s, 4'h9);
		w(4);
		q(s[2:0], E, 16'h0000);
		src(s, 4'h0);
		w(4);
		q(s[2:0], E, 16'h0012);
		ptr[s] <= 16'hffff;
		ntr[s] <= 16'h0000;
	endtask
	task s_trig_meas;
		trg <= 4'h1;
		mea <= 4'h1;
		w(4);
		q(3'h3, C, 16'h0000);
		q(3'h2, C, 16'h0002);
		trg <= 4'h0;
		mea <= 4'h0;
		w(4);
		q(3'h2, E, 16'h0002);
	endtask
	task s_misc;
		for (int i = 5; i < 8; i++)
			q(i[2:0], E, 16'h0000);
		ll <= 1'b1;
		ul <= 1'b1;
		w(4);
		q(3'h0, C, 16'h1800);
		ll <= 1'b0;
		ul <= 1'b0;
		w(4);
		chk("summary_cond_out", sum, 16'h0000);
		en[1] <= 16'h0000;
		src(1, 4'h9);
		w(4);
		q(3'h0, C, 16'h0000);
		q(3'h1, E, 16'h0012);
		src(1, 4'h0);
		en[1] <= 16'hffff;
	endtask
	task s_init;
		dn <= 4'hf;
		w(1);
		dn <= 4'h0;
		w(4);
		q(3'h4, C, 16'h0000);
		con <= 4'h2;
		w(4);
		q(3'h4, C, 16'h0004);
		q(3'h4, E, 16'h0004);
		pre <= 1'b1;
		w(1);
		pre <= 1'b0;
		w(4);
		q(3'h4, C, 16'h001e);
		q(3'h4, E, 16'h001a);
	endtask
	initial
	begin
		w(6);
		resetn_in <= 1'b1;
		s_power_up();
		for (int s = 1; s < 4; s++)
			s_sub(s);
		s_trig_meas();
		s_misc();
		s_init();
		final_report();
	end
endmodule
bind osh_top osh_top_monitor mon_u (.clk_in(clk_in), .resetn_in(resetn_in),
	.query_valid_in(query_valid_in), .query_sel_in(query_sel_in),
	.lower_limit_fail_in(lower_limit_fail_in), .upper_limit_fail_in(upper_limit_fail_in),
	.answer_valid_out(answer_valid_out), .answer_out(answer_out),
	.summary_cond_out(summary_cond_out));
